// file: pkg/eac_pkg.sv
// Constants, types and carriers for the EEPROM access controller.
// Assumes a 100 MHz system clock and a byte-wide EEPROM array.
package eac_pkg;

    // Clock and programming times.
    localparam int unsigned EAC_CLK_PERIOD_NS = 10;
    localparam int unsigned EAC_T_ATOMIC_NS = 3400000;
    localparam int unsigned EAC_T_SPLIT_NS = 1800000;
    localparam int unsigned EAC_ATOMIC_CYC = EAC_T_ATOMIC_NS / EAC_CLK_PERIOD_NS;
    localparam int unsigned EAC_SPLIT_CYC = EAC_T_SPLIT_NS / EAC_CLK_PERIOD_NS;
    localparam int unsigned EAC_CNT_W = 19;

    // Short sequencing counts.
    localparam logic [2:0] EAC_ARM_CYC = 3'h4;
    localparam logic [2:0] EAC_PROG_STALL_CYC = 3'h2;
    localparam logic [2:0] EAC_READ_STALL_CYC = 3'h4;

    // Register bus map.
    localparam int unsigned EAC_BUS_AW = 2;
    localparam logic [1:0] EAC_REG_CTRL = 2'h0;
    localparam logic [1:0] EAC_REG_ADDR_LO = 2'h1;
    localparam logic [1:0] EAC_REG_ADDR_HI = 2'h2;
    localparam logic [1:0] EAC_REG_DATA = 2'h3;

    // Control register field positions and widths.
    localparam int unsigned EAC_READ_BIT = 0;
    localparam int unsigned EAC_PROG_BIT = 1;
    localparam int unsigned EAC_ARM_BIT = 2;
    localparam int unsigned EAC_IRQEN_BIT = 3;
    localparam int unsigned EAC_MODE_LSB = 4;
    localparam int unsigned EAC_MODE_MSB = 5;
    localparam int unsigned EAC_DATA_W = 8;
    localparam int unsigned EAC_NVM_AW = 9;
    localparam logic [7:0] EAC_DATA_RST = 8'h00;
    localparam logic [8:0] EAC_ADDR_RST = 9'h000;

    typedef enum logic [1:0] {
        EAC_MODE_ATOMIC = 2'h0,
        EAC_MODE_ERASE = 2'h1,
        EAC_MODE_WRITE = 2'h2,
        EAC_MODE_RSVD = 2'h3
    } eac_mode_t;

    typedef enum logic [1:0] {
        EAC_ST_IDLE = 2'b01,
        EAC_ST_PROG = 2'b10
    } eac_state_t;

    // Signals toward the EEPROM array.
    typedef struct packed {
        logic [EAC_NVM_AW-1:0] addr;
        logic [EAC_DATA_W-1:0] wdata;
        logic erase;
        logic write;
        logic rd;
    } eac_nvm_t;

endpackage

// file: rtl/eac_top.sv
// EEPROM access controller: control, address and data registers, timed
// arming of program operations, per-mode programming timer, read strobe
// and CPU stall. Assumes a byte-wide array with combinational read data.
//
// Contract
// RULE_01: Program trigger within four cycles after arming starts programming.
// RULE_02: Program trigger without arming is ignored.
// RULE_03: Arm bit clears itself four cycles after being written one.
// RULE_04: A valid trigger performs the operation of the mode field.
// RULE_05: Program bit stays set while busy, cleared by hardware at end.
// RULE_06: Program trigger stalls the CPU for two cycles.
// RULE_07: Read strobe loads the addressed byte into the data register.
// RULE_08: Read trigger stalls the CPU for four cycles.
// RULE_09: While busy, reads are not performed and address writes ignored.
// RULE_10: Software polls the busy flag before triggering a read.
// RULE_11: Software loads the address before triggering a read.
// RULE_12: Software arms before writing the program bit.
// RULE_13: Mode 00 atomic, 01 erase, 10 write, 11 reserved.
// RULE_14: Mode field writes are ignored while busy.
// RULE_15: System reset clears mode field unless programming is busy.
// RULE_16: With ready interrupt enabled, interrupt level shows not busy.
// RULE_17: Programming time is a per-mode cycle counter, clearing busy.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
module eac_top import eac_pkg::*; #(
    parameter int unsigned ATOMIC_CYCLES = EAC_ATOMIC_CYC,
    parameter int unsigned SPLIT_CYCLES = EAC_SPLIT_CYC
) (
    // Clock and resets.
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic por_n_i,
    // Register bus.
    input wire logic [EAC_BUS_AW-1:0] addr_i,
    input wire logic [EAC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [EAC_DATA_W-1:0] rdata_o,
    // CPU side status.
    output logic cpu_stall_o,
    output logic ready_irq_o,
    // EEPROM array.
    output eac_nvm_t nvm_o,
    input wire logic [EAC_DATA_W-1:0] nvm_rdata_i
);

    localparam logic [EAC_CNT_W-1:0] ATOMIC_LOAD =
        EAC_CNT_W'(ATOMIC_CYCLES - 1);
    localparam logic [EAC_CNT_W-1:0] SPLIT_LOAD =
        EAC_CNT_W'(SPLIT_CYCLES - 1);

    // Register state held by the system reset.
    logic arm_reg, arm_next;
    logic [2:0] arm_cnt_reg, arm_cnt_next;
    logic irq_en_reg, irq_en_next;
    logic [EAC_NVM_AW-1:0] addr_reg, addr_next;
    logic [EAC_DATA_W-1:0] data_reg, data_next;
    logic [2:0] stall_cnt_reg, stall_cnt_next;
    logic stall_o_next;
    logic [EAC_DATA_W-1:0] rdata_next;
    logic rd_req_reg, rd_req_next;

    // Programming engine, held only by power-on reset so that a system
    // reset never cuts an erase or write short.
    eac_state_t state_reg, state_next;
    eac_mode_t mode_reg, mode_next;
    eac_mode_t run_mode_reg, run_mode_next;
    logic [EAC_CNT_W-1:0] prog_cnt_reg, prog_cnt_next;
    logic rst_meta_reg, rst_sync_reg;
    logic irq_next;
    eac_nvm_t nvm_next;

    logic ctrl_wr, busy, prog_trig, read_trig;
    eac_mode_t wr_mode;

    assign ctrl_wr = wr_i && (addr_i == EAC_REG_CTRL);
    assign busy = (state_reg == EAC_ST_PROG);
    assign wr_mode = eac_mode_t'(wdata_i[EAC_MODE_MSB:EAC_MODE_LSB]);
    // RULE_01 RULE_02 RULE_12 armed trigger only.
    assign prog_trig = ctrl_wr && wdata_i[EAC_PROG_BIT] && arm_reg &&
                       !busy && (wr_mode != EAC_MODE_RSVD);
    // RULE_09 RULE_10 no read while busy.
    assign read_trig = ctrl_wr && wdata_i[EAC_READ_BIT] && !busy &&
                       !prog_trig;

    // Register and stall next values.
    always_comb begin
        arm_next = arm_reg;
        arm_cnt_next = arm_cnt_reg;
        irq_en_next = irq_en_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        stall_cnt_next = stall_cnt_reg;
        rdata_next = '0;
        rd_req_next = read_trig;
        // A fresh arm write restarts the window rather than extending it,
        // so software always gets the full four cycles from its last write.
        // RULE_03 arm window timeout.
        if (ctrl_wr && wdata_i[EAC_ARM_BIT]) begin
            arm_next = 1'b1;
            arm_cnt_next = EAC_ARM_CYC - 3'h1;
        end else if (arm_reg) begin
            if (arm_cnt_reg == 3'h0) begin
                arm_next = 1'b0;
            end else begin
                arm_cnt_next = arm_cnt_reg - 3'h1;
            end
        end
        if (ctrl_wr) begin
            irq_en_next = wdata_i[EAC_IRQEN_BIT];
        end
        // RULE_09 address frozen while busy.
        if (wr_i && !busy && addr_i == EAC_REG_ADDR_LO) begin
            addr_next[7:0] = wdata_i;
        end else if (wr_i && !busy && addr_i == EAC_REG_ADDR_HI) begin
            addr_next[EAC_NVM_AW-1] = wdata_i[0];
        end else if (wr_i && !busy && addr_i == EAC_REG_DATA) begin
            data_next = wdata_i;
        end
        // The array answers in the cycle of its read pulse, so the byte is
        // taken one cycle after the trigger and never waits on the array.
        // RULE_07 capture array byte.
        if (rd_req_reg) begin
            data_next = nvm_rdata_i;
        end
        // RULE_06 RULE_08 stall counts.
        if (prog_trig) begin
            stall_cnt_next = EAC_PROG_STALL_CYC;
        end else if (read_trig) begin
            stall_cnt_next = EAC_READ_STALL_CYC;
        end else if (stall_cnt_reg != 3'h0) begin
            stall_cnt_next = stall_cnt_reg - 3'h1;
        end
        stall_o_next = (stall_cnt_next != 3'h0);
        if (rd_i && addr_i == EAC_REG_CTRL) begin
            rdata_next = {2'h0, mode_reg, irq_en_reg, arm_reg, busy, 1'b0};
        end else if (rd_i && addr_i == EAC_REG_ADDR_LO) begin
            rdata_next = addr_reg[7:0];
        end else if (rd_i && addr_i == EAC_REG_ADDR_HI) begin
            rdata_next = {7'h00, addr_reg[EAC_NVM_AW-1]};
        end else if (rd_i && addr_i == EAC_REG_DATA) begin
            rdata_next = data_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arm_reg <= 1'b0;
            arm_cnt_reg <= 3'h0;
            irq_en_reg <= 1'b0;
            addr_reg <= EAC_ADDR_RST;
            data_reg <= EAC_DATA_RST;
            stall_cnt_reg <= 3'h0;
            cpu_stall_o <= 1'b0;
            rdata_o <= '0;
            rd_req_reg <= 1'b0;
        end else begin
            arm_reg <= arm_next;
            arm_cnt_reg <= arm_cnt_next;
            irq_en_reg <= irq_en_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            stall_cnt_reg <= stall_cnt_next;
            cpu_stall_o <= stall_o_next;
            rdata_o <= rdata_next;
            rd_req_reg <= rd_req_next;
        end
    end

    // Programming engine next values.
    always_comb begin
        state_next = state_reg;
        mode_next = mode_reg;
        run_mode_next = run_mode_reg;
        prog_cnt_next = prog_cnt_reg;
        // RULE_14 mode locked while busy.
        if (ctrl_wr && !busy) begin
            mode_next = wr_mode;
        end
        // RULE_15 mode cleared by idle reset.
        if (!rst_sync_reg && !busy) begin
            mode_next = EAC_MODE_ATOMIC;
        end
        case (state_reg)
            EAC_ST_IDLE: begin
                // RULE_04 RULE_13 RULE_17 mode timer load.
                if (prog_trig) begin
                    state_next = EAC_ST_PROG;
                    run_mode_next = wr_mode;
                    prog_cnt_next = (wr_mode == EAC_MODE_ATOMIC) ?
                                    ATOMIC_LOAD : SPLIT_LOAD;
                end
            end
            EAC_ST_PROG: begin
                // RULE_05 RULE_17 busy ends at expiry.
                if (prog_cnt_reg == '0) begin
                    state_next = EAC_ST_IDLE;
                end else begin
                    prog_cnt_next = prog_cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = EAC_ST_IDLE;
            end
        endcase
        // RULE_16 ready level.
        irq_next = irq_en_next && (state_next == EAC_ST_IDLE);
        nvm_next.addr = addr_next;
        nvm_next.wdata = data_next;
        nvm_next.rd = rd_req_next;
        // RULE_04 RULE_13 array strobes per mode.
        nvm_next.erase = (state_next == EAC_ST_PROG) &&
                         (run_mode_next != EAC_MODE_WRITE);
        nvm_next.write = (state_next == EAC_ST_PROG) &&
                         (run_mode_next != EAC_MODE_ERASE);
    end

    always_ff @(posedge sys_clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            state_reg <= EAC_ST_IDLE;
            mode_reg <= EAC_MODE_ATOMIC;
            run_mode_reg <= EAC_MODE_ATOMIC;
            prog_cnt_reg <= '0;
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
            ready_irq_o <= 1'b0;
            nvm_o <= '0;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            run_mode_reg <= run_mode_next;
            prog_cnt_reg <= prog_cnt_next;
            // Two stages, since the system reset arrives with no relation
            // to this clock.
            rst_meta_reg <= rstn_i;
            rst_sync_reg <= rst_meta_reg;
            ready_irq_o <= irq_next;
            nvm_o <= nvm_next;
        end
    end

    // Checks are off while either reset is low, since the two reset
    // domains release at different edges.
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!por_n_i || !rstn_i);

    AST_ARM_CLEAR: assert property ( // RULE_03
        $rose(arm_reg) ##0 !(ctrl_wr && wdata_i[EAC_ARM_BIT]) [*4]
        |-> arm_reg ##1 !arm_reg)
        else $error("arm bit did not clear after four cycles");
    AST_PROG_START: assert property ( // RULE_01
        prog_trig |=> busy ##1 (nvm_o.erase || nvm_o.write))
        else $error("armed program trigger did not start programming");
    AST_NO_ARM: assert property ( // RULE_02
        ctrl_wr && wdata_i[EAC_PROG_BIT] && !arm_reg && !busy |=> !busy)
        else $error("program started without arming");
    AST_MODE_ERASE: assert property ( // RULE_04
        prog_trig && wr_mode == EAC_MODE_ERASE
        |=> ##1 nvm_o.erase && !nvm_o.write)
        else $error("erase-only mode drove wrong array strobes");
    AST_MODE_ATOMIC: assert property ( // RULE_13
        prog_trig && wr_mode == EAC_MODE_ATOMIC
        |=> prog_cnt_reg == ATOMIC_LOAD ##1 nvm_o.erase && nvm_o.write)
        else $error("atomic mode not loaded with its time");
    AST_BUSY_END: assert property ( // RULE_05
        $fell(busy) |-> $past(prog_cnt_reg) == '0 && !nvm_o.write ##1
        !nvm_o.erase && !nvm_o.write)
        else $error("busy cleared before timer expiry");
    AST_PROG_STALL: assert property ( // RULE_06
        prog_trig |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
        else $error("program stall is not two cycles");
    AST_READ_STALL: assert property ( // RULE_08
        read_trig ##1 !(read_trig || prog_trig) [*4]
        |-> cpu_stall_o && $past(cpu_stall_o) && $past(cpu_stall_o, 2) &&
            $past(cpu_stall_o, 3) ##1 !cpu_stall_o)
        else $error("read stall is not four cycles");
    AST_READ_DATA: assert property ( // RULE_07
        read_trig |=> nvm_o.rd ##1 data_reg == $past(nvm_rdata_i))
        else $error("read strobe did not load the data register");
    AST_BUSY_NO_READ: assert property ( // RULE_09
        busy && wr_i |=> !nvm_o.rd ##0 $stable(addr_reg))
        else $error("read or address change while busy");
    AST_MODE_LOCK: assert property ( // RULE_14
        busy && ctrl_wr |=> $stable(mode_reg))
        else $error("mode changed while busy");
    AST_IRQ_LEVEL: assert property ( // RULE_16
        ready_irq_o == (irq_en_reg && !busy))
        else $error("ready interrupt level wrong");
    AST_MODE_CLEAR: assert property ( // RULE_15
        !rst_sync_reg && !busy |=> mode_reg == EAC_MODE_ATOMIC)
        else $error("mode field kept through an idle reset");
    AST_SPLIT_LOAD: assert property ( // RULE_17
        prog_trig && wr_mode != EAC_MODE_ATOMIC
        |=> prog_cnt_reg == SPLIT_LOAD)
        else $error("split mode not loaded with its time");

    COV_PROG: cover property (prog_trig ##1 busy [*3]);
    COV_READ: cover property (read_trig ##5 !cpu_stall_o ##0 !busy);
    COV_REJECT: cover property (ctrl_wr && wdata_i[EAC_PROG_BIT] &&
                                !arm_reg);
    COV_ARM_LATE: cover property ($fell(arm_reg) ##0 (ctrl_wr &&
                                  wdata_i[EAC_PROG_BIT]));
    COV_SPLIT: cover property (prog_trig && wr_mode == EAC_MODE_WRITE
                               ##2 nvm_o.write);

endmodule

// file: verification/eac_nvm_model.sv
// Behavioural model of the byte-wide EEPROM array behind the controller.
// Assumes the controller holds address and data steady while programming.
`timescale 1ns/1ns
module eac_nvm_model import eac_pkg::*; (
    // Clock.
    input wire logic sys_clk_i,
    // Array side of the controller.
    input wire eac_nvm_t nvm_i,
    output logic [EAC_DATA_W-1:0] rdata_o
);
    logic [EAC_DATA_W-1:0] mem [0:(1 << EAC_NVM_AW) - 1];
    logic [EAC_DATA_W-1:0] last;
    logic busy;
    logic do_er;
    logic do_wr;

    initial begin
        for (int i = 0; i < (1 << EAC_NVM_AW); i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
        end
        last = 8'h00;
        busy = 1'b0;
        do_er = 1'b0;
        do_wr = 1'b0;
    end

    // byte on read
    // Outside a read pulse the lines show the inverse of the last byte.
    assign rdata_o = nvm_i.rd ? mem[nvm_i.addr] : ~last;

    always @(posedge sys_clk_i) begin
        if (nvm_i.rd) begin
            last <= mem[nvm_i.addr];
        end
    end

    // mode operations
    // Address and data are taken at the end, so a change mid-way shows.
    always @(posedge sys_clk_i) begin
        if (nvm_i.erase || nvm_i.write) begin
            busy <= 1'b1;
            do_er <= do_er | nvm_i.erase;
            do_wr <= do_wr | nvm_i.write;
        end else if (busy) begin
            if (do_wr) begin
                mem[nvm_i.addr] <= (do_er ? 8'hff : mem[nvm_i.addr])
                    & nvm_i.wdata;
            end else if (do_er) begin
                mem[nvm_i.addr] <= 8'hff;
            end
            busy <= 1'b0;
            do_er <= 1'b0;
            do_wr <= 1'b0;
        end
    end
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the EEPROM access controller.
// Assumes the array model beside it and shortened programming times.
`timescale 1ns/1ns
module tb_top import eac_pkg::*;;
    localparam int unsigned NA = 20;
    localparam int unsigned NS = 10;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic por_n_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [7:0] nvm_rdata_i;
    logic [7:0] q;
    logic cpu_stall_o;
    logic ready_irq_o;
    eac_nvm_t nvm_o;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int rd_pulses = 0;

    eac_top #(.ATOMIC_CYCLES(NA), .SPLIT_CYCLES(NS)) dut (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .por_n_i(por_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .cpu_stall_o(cpu_stall_o),
        .ready_irq_o(ready_irq_o), .nvm_o(nvm_o),
        .nvm_rdata_i(nvm_rdata_i)
    );

    eac_nvm_model model (
        .sys_clk_i(sys_clk_i), .nvm_i(nvm_o), .rdata_o(nvm_rdata_i)
    );

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic end_sim();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and closes the run.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (nvm_o.rd === 1'b1) rd_pulses++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 q = rdata_o;
    endtask

    task automatic stall(input int n);
        int s;
        s = 0;
        repeat (5) begin
            #1 if (cpu_stall_o === 1'b1) s++;
            @(posedge sys_clk_i);
        end
        chk("stall", 8'(n), 8'(s));
    endtask

    task automatic rdbyte(input logic [8:0] a, input logic [7:0] e);
        rd(EAC_REG_CTRL);
        chk("idle", 8'h00, q & 8'h02);
        wr(EAC_REG_ADDR_LO, a[7:0]);
        wr(EAC_REG_ADDR_HI, {7'h00, a[8]});
        wr(EAC_REG_CTRL, 8'h01);
        stall(4);
        rd(EAC_REG_DATA);
        chk("data", e, q);
    endtask

    // Gap plus one is the idle cycles between arm and trigger; below zero, no arm.
    task automatic prog(input logic [1:0] m, input int gap,
                        input logic ien, input logic med);
        logic [7:0] c;
        logic ok;
        int n;
        int p;
        c = {2'b00, m, ien, 3'b000};
        ok = (m != 2'h3) && (gap >= 0) && (gap <= 2);
        n = (m == 2'h0) ? NA : NS;
        if (gap >= 0) begin
            wr(EAC_REG_CTRL, c | 8'h04);
            repeat (gap) @(posedge sys_clk_i);
        end
        wr(EAC_REG_CTRL, c | 8'h02);
        stall(ok ? 2 : 0);
        if (med) begin
            p = rd_pulses;
            wr(EAC_REG_ADDR_LO, 8'h77);
            wr(EAC_REG_DATA, 8'h11);
            wr(EAC_REG_CTRL, {4'h1, ien, 3'b001});
            @(posedge sys_clk_i);
            #1;
            chk("rd_pulse", 8'(p), 8'(rd_pulses));
            chk("addr", 8'h05, nvm_o.addr[7:0]);
        end
        repeat (n - (med ? 16 : 9)) @(posedge sys_clk_i);
        rd(EAC_REG_CTRL);
        chk("busy", ok ? (c | 8'h02) : c, q);
        chk("strobes", ok ? {6'h00, m != 2'h2, m != 2'h1} : 8'h00,
            {6'h00, nvm_o.erase, nvm_o.write});
        chk("irq", {7'h00, ien & !ok}, {7'h00, ready_irq_o});
        repeat (6) @(posedge sys_clk_i);
        rd(EAC_REG_CTRL);
        chk("done", c, q);
        chk("irq", {7'h00, ien}, {7'h00, ready_irq_o});
    endtask

    initial begin
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        por_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd(EAC_REG_CTRL);
        chk("ctrl", 8'h00, q);
        rd(EAC_REG_DATA);
        chk("data", EAC_DATA_RST, q);
        chk("irq", 8'h00, {7'h00, ready_irq_o});
        wr(EAC_REG_CTRL, 8'h04);
        rd(EAC_REG_CTRL);
        chk("arm", 8'h04, q);
        repeat (3) @(posedge sys_clk_i);
        rd(EAC_REG_CTRL);
        chk("arm", 8'h00, q);
        rdbyte(9'h1ff, 8'h5a);
        wr(EAC_REG_ADDR_LO, 8'h05);
        wr(EAC_REG_ADDR_HI, 8'h00);
        wr(EAC_REG_DATA, 8'h3c);
        prog(2'h0, 0, 1'b1, 1'b1);
        rdbyte(9'h005, 8'h3c);
        prog(2'h1, 2, 1'b0, 1'b0);
        rdbyte(9'h005, 8'hff);
        wr(EAC_REG_DATA, 8'h5a);
        prog(2'h2, 0, 1'b1, 1'b0);
        rdbyte(9'h005, 8'h5a);
        prog(2'h3, 0, 1'b0, 1'b0);
        prog(2'h0, 3, 1'b0, 1'b0);
        prog(2'h0, -1, 1'b1, 1'b0);
        rdbyte(9'h005, 8'h5a);
        wr(EAC_REG_CTRL, 8'h10);
        rstn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rd(EAC_REG_CTRL);
        chk("mode", 8'h00, q);
        end_sim();
    end
endmodule
